// File: hdl/btr_pkg.sv
// Purpose: shared constants and types of the branch trace recorder
// Assumes: 24-bit storage addresses, program levels 1 to 5
// Notes: entry layout is most significant byte first

package btr_pkg;

    // ************************************************
    // widths
    // ************************************************
    localparam int ADDR_W = 32'h18;        // storage address width
    localparam int CNT_W = 32'h10;         // entry count width
    localparam int LVL_W = 32'h3;          // program level width
    localparam int NUM_LVL = 32'h5;        // levels one to five
    localparam int ENTRY_BYTES = 32'h8;    // bytes per trace entry

    // ************************************************
    // external input codes for readback
    // ************************************************
    localparam logic [7:0] EXT_CODE_BASE = 8'h7b;  // buffer start address
    localparam logic [7:0] EXT_CODE_CNT = 8'h7c;   // buffer count

    // ************************************************
    // reset values
    // ************************************************
    localparam logic [ADDR_W-1:0] BASE_RST = 24'h000000;
    localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [4:0] LVL_PAD = 5'h00;        // upper bits of a level byte

    // kinds of branch event offered by the core
    typedef enum logic [1:0] {
        KIND_BRANCH = 2'h0,  // taken branch instruction
        KIND_IARW = 2'h1,    // write to the instruction address register
        KIND_INTR = 2'h2,    // program interrupt
        KIND_EXIT = 2'h3     // return from interrupt
    } btr_kind_type;

    // recorder states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,   // waiting for an event
        ST_STORE = 2'h2   // entry store outstanding
    } btr_state_type;

    // one eight-byte entry, byte 0 in the top bits
    typedef struct packed {
        logic [7:0] src_lvl;
        logic [ADDR_W-1:0] src_addr;
        logic [7:0] tgt_lvl;
        logic [ADDR_W-1:0] tgt_addr;
    } btr_entry_type;

endpackage

// File: hdl/btr_setup_if.sv
// Purpose: carries buffer setup values from the setup holder to the recorder
// Assumes: both ends on clk
// Notes: pend stays high until the recorder returns taken

`timescale 1ns/100ps
`default_nettype none

interface btr_setup_if;
    logic [btr_pkg::ADDR_W-1:0] base;  // buffer start address
    logic [btr_pkg::CNT_W-1:0] count;  // buffer size in entries
    logic pend;                        // new values not yet applied
    logic taken;                       // recorder applied them this cycle

    modport prov (output base, output count, output pend, input taken);
    modport use_side (input base, input count, input pend, output taken);
endinterface

`default_nettype wire

// File: hdl/btr_scope.sv
// Purpose: decides whether one address and level lie in the traced scope
// Assumes: level zero is never selected
// Notes: purely combinational, used once for each side of a branch

`timescale 1ns/100ps
`default_nettype none

module btr_scope #(
    parameter int AW = btr_pkg::ADDR_W,
    parameter int LW = btr_pkg::LVL_W,
    parameter int NL = btr_pkg::NUM_LVL
) (
    input wire logic [AW-1:0] addr,
    input wire logic [LW-1:0] level,
    input wire logic [AW-1:0] range_lo,
    input wire logic [AW-1:0] range_hi,
    input wire logic [NL-1:0] level_sel,
    output logic in_scope
);
    logic lvl_ok;  // level is one of the selected ones
    logic adr_ok;  // address inside the inclusive range

    // ************************************************
    // level match
    // ************************************************
    always_comb begin
        lvl_ok = 1'b0;
        for (int i = 0; i < NL; i++) begin
            if (level_sel[i] && (level == LW'(i + 1))) begin
                lvl_ok = 1'b1;
            end
        end
    end

    assign adr_ok = (addr >= range_lo) && (addr <= range_hi);
    assign in_scope = adr_ok && lvl_ok;
endmodule // btr_scope

`default_nettype wire

// File: hdl/btr_setup.sv
// Purpose: holds buffer start address and count from two loaders
// Assumes: load strobes are one-cycle pulses on clk
// Notes: the maintenance loader wins a same-cycle clash

`timescale 1ns/100ps
`default_nettype none

module btr_setup (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mss_load,
    input wire logic [btr_pkg::ADDR_W-1:0] mss_base,
    input wire logic [btr_pkg::CNT_W-1:0] mss_count,
    input wire logic cp_load,
    input wire logic [btr_pkg::ADDR_W-1:0] cp_base,
    input wire logic [btr_pkg::CNT_W-1:0] cp_count,
    btr_setup_if.prov sif
);
    typedef struct packed {
        logic [btr_pkg::ADDR_W-1:0] base;
        logic [btr_pkg::CNT_W-1:0] count;
        logic pend;
    } btr_setup_type;

    localparam btr_setup_type SETUP_RST = '{
        base: btr_pkg::BASE_RST, count: btr_pkg::COUNT_RST, pend: 1'b0};

    btr_setup_type r;       // registered state
    btr_setup_type next_r;  // next state

    // ************************************************
    // load selection
    // ************************************************
    always_comb begin
        next_r = r;
        if (sif.taken) begin
            next_r.pend = 1'b0;  // applied by the recorder
        end
        // a later maintenance load overrides a program load
        if (mss_load) begin
            next_r.base = mss_base;
            next_r.count = mss_count;
            next_r.pend = 1'b1;      // new load beats the taken clear
        end else if (cp_load) begin
            next_r.base = cp_base;
            next_r.count = cp_count;
            next_r.pend = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= SETUP_RST;
        end else begin
            r <= next_r;
        end
    end

    assign sif.base = r.base;
    assign sif.count = r.count;
    assign sif.pend = r.pend;
endmodule // btr_setup

`default_nettype wire

// File: hdl/btr_recorder.sv
// Purpose: branch trace recorder beside the central control unit
// Assumes: core and maintenance subsystem run on clk; one store port
// Notes: core holds off new events while core_stall is high

`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - one eight-byte entry per traced branch
// - interrupts and returns recorded as branches
// - byte layout: srclvl, srcaddr, tgtlvl, tgtaddr
// - branch or register write: both levels current
// - interrupt: old level/address, new level/address
// - return: exited level/address, resumed level/address
// - levels written as binary 01 to 05
// - start address and entry count set first
// - record only inside the address range
// - record only on selected levels
// - wrap overwrites oldest entries from start
// - stop-on-address keeps latest entries before stop
// - start address readable at code 7B
// - buffer count readable at code 7C
// - core stalled while an entry stores
// - maintenance may overwrite program-set values
module btr_recorder #(
    parameter int CW = btr_pkg::CNT_W,   // entry count width
    parameter int NL = btr_pkg::NUM_LVL  // number of program levels
) (
    input wire logic clk,
    input wire logic rst_n,

    // branch events from the core
    input wire logic ev_valid,
    input wire btr_pkg::btr_kind_type ev_kind,
    input wire logic [btr_pkg::LVL_W-1:0] ev_src_level,
    input wire logic [btr_pkg::ADDR_W-1:0] ev_src_addr,

    input wire logic [btr_pkg::LVL_W-1:0] ev_tgt_level,
    input wire logic [btr_pkg::ADDR_W-1:0] ev_tgt_addr,
    output logic core_stall,

    // trace options
    input wire logic trace_enable,
    input wire logic wrap_enable,
    input wire logic stop_enable,
    input wire logic [btr_pkg::ADDR_W-1:0] stop_addr,
    input wire logic [btr_pkg::ADDR_W-1:0] range_lo,
    input wire logic [btr_pkg::ADDR_W-1:0] range_hi,
    input wire logic [NL-1:0] level_sel,

    // buffer setup from two loaders
    input wire logic mss_load,
    input wire logic [btr_pkg::ADDR_W-1:0] mss_base,
    input wire logic [btr_pkg::CNT_W-1:0] mss_count,

    input wire logic cp_load,
    input wire logic [btr_pkg::ADDR_W-1:0] cp_base,
    input wire logic [btr_pkg::CNT_W-1:0] cp_count,

    // storage write port
    output logic mem_req,
    output logic [btr_pkg::ADDR_W-1:0] mem_addr,
    output logic [63:0] mem_data,
    input wire logic mem_ack,

    // external input readback
    input wire logic ext_rd,
    input wire logic [7:0] ext_code,
    output logic ext_valid,
    output logic [btr_pkg::ADDR_W-1:0] ext_data,

    // status
    output logic trace_full,
    output logic stop_hit,
    output logic [CW-1:0] entries_left
);

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        btr_pkg::btr_state_type st;       // sequencer state
        logic [btr_pkg::ADDR_W-1:0] ptr;  // next store address
        logic [CW-1:0] remain;            // entries left before end
        btr_pkg::btr_entry_type entry;    // entry being stored

        logic mem_req;                    // store request
        logic stall;                      // hold the core

        logic full;                       // buffer ended, no wrap
        logic stop_pend;                  // entry hit stop address
        logic stopped;                    // recording frozen

        logic ext_valid;                  // readback answer
        logic [btr_pkg::ADDR_W-1:0] ext_data;
    } btr_rec_type;

    localparam btr_rec_type REC_RST = '{
        st: btr_pkg::ST_IDLE,
        ptr: btr_pkg::BASE_RST,
        remain: CW'(btr_pkg::COUNT_RST),
        default: '0};

    // pointer step of one entry
    localparam logic [btr_pkg::ADDR_W-1:0] STEP =
        btr_pkg::ADDR_W'(btr_pkg::ENTRY_BYTES);

    btr_rec_type r;        // registered state
    btr_rec_type next_r;   // next state

    btr_setup_if sif ();   // setup values from the holder

    logic src_ok;          // source side in scope
    logic tgt_ok;          // target side in scope
    logic take;            // accept the offered event

    btr_pkg::btr_entry_type built;  // entry formed from the event

    // ************************************************
    // setup holder and scope checks
    // ************************************************
    btr_setup u_setup (
        .clk(clk),
        .rst_n(rst_n),
        .mss_load(mss_load),
        .mss_base(mss_base),
        .mss_count(mss_count),
        .cp_load(cp_load),
        .cp_base(cp_base),
        .cp_count(cp_count),
        .sif(sif)
    );

    // the source side decides for branches made inside a level
    btr_scope #(.NL(NL)) u_src_scope (
        .addr(ev_src_addr),
        .level(ev_src_level),
        .range_lo(range_lo),
        .range_hi(range_hi),
        .level_sel(level_sel),
        .in_scope(src_ok)
    );

    // the target side catches entries into a traced level
    btr_scope #(.NL(NL)) u_tgt_scope (
        .addr(ev_tgt_addr),
        .level(ev_tgt_level),
        .range_lo(range_lo),
        .range_hi(range_hi),
        .level_sel(level_sel),
        .in_scope(tgt_ok)
    );

    // setup is applied only between stores so no entry is split
    assign sif.taken = sif.pend && (r.st == btr_pkg::ST_IDLE);

    // ************************************************
    // entry formation
    // ************************************************
    always_comb begin
        built.src_addr = ev_src_addr;
        built.tgt_addr = ev_tgt_addr;

        case (ev_kind)
            btr_pkg::KIND_BRANCH, btr_pkg::KIND_IARW: begin
                // both level bytes carry the current level
                built.src_lvl = {btr_pkg::LVL_PAD, ev_src_level};
                built.tgt_lvl = {btr_pkg::LVL_PAD, ev_src_level};
            end

            btr_pkg::KIND_INTR, btr_pkg::KIND_EXIT: begin
                // old or exited level, then the level entered
                built.src_lvl = {btr_pkg::LVL_PAD, ev_src_level};
                built.tgt_lvl = {btr_pkg::LVL_PAD, ev_tgt_level};
            end

            default: begin
                built.src_lvl = {btr_pkg::LVL_PAD, ev_src_level};
                built.tgt_lvl = {btr_pkg::LVL_PAD, ev_tgt_level};
            end
        endcase
    end

    // every event kind is traced alike once in scope
    assign take = trace_enable && ev_valid && (src_ok || tgt_ok)
        && !r.full
        && !r.stopped
        && (r.remain != '0);

    // ************************************************
    // sequencer
    // ************************************************
    always_comb begin
        next_r = r;
        next_r.ext_valid = 1'b0;

        // readback answers the cycle after the request
        if (ext_rd) begin
            next_r.ext_valid = 1'b1;

            if (ext_code == btr_pkg::EXT_CODE_BASE) begin
                next_r.ext_data = sif.base;
            end else if (ext_code == btr_pkg::EXT_CODE_CNT) begin
                next_r.ext_data = btr_pkg::ADDR_W'(sif.count);
            end else begin
                next_r.ext_data = '0;  // unknown code reads zero
            end
        end

        case (r.st)
            btr_pkg::ST_IDLE: begin
                if (sif.taken) begin
                    // fresh buffer: restart from the top
                    next_r.ptr = sif.base;
                    next_r.remain = CW'(sif.count);

                    next_r.full = 1'b0;
                    next_r.stopped = 1'b0;
                    next_r.stop_pend = 1'b0;
                end else if (take) begin
                    next_r.entry = built;

                    next_r.mem_req = 1'b1;
                    next_r.stall = 1'b1;

                    next_r.stop_pend = stop_enable && (ev_src_addr == stop_addr);
                    next_r.st = btr_pkg::ST_STORE;
                end
            end

            btr_pkg::ST_STORE: begin
                // request and stall stand until the store is acknowledged
                if (mem_ack) begin

                    next_r.mem_req = 1'b0;
                    next_r.stall = 1'b0;
                    next_r.st = btr_pkg::ST_IDLE;

                    next_r.ptr = r.ptr + STEP;
                    next_r.remain = r.remain - CW'(1);

                    if (r.remain == CW'(1)) begin
                        if (wrap_enable) begin
                            // oldest entries are overwritten from the start
                            next_r.ptr = sif.base;
                            next_r.remain = CW'(sif.count);
                        end else begin
                            next_r.full = 1'b1;
                        end
                    end

                    // freeze after the stop entry so the latest n survive
                    if (r.stop_pend) begin
                        next_r.stopped = 1'b1;
                        next_r.stop_pend = 1'b0;
                    end
                end
            end

            default: begin
                next_r = REC_RST;  // illegal code recovers to idle
            end
        endcase

        // a disabled trace releases a freeze so it can be rearmed
        if (!trace_enable && (r.st == btr_pkg::ST_IDLE)) begin
            next_r.stopped = 1'b0;
        end
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= REC_RST;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************
    // outputs, all from state flops
    // ************************************************
    assign core_stall = r.stall;
    assign mem_req = r.mem_req;
    assign mem_addr = r.ptr;
    assign mem_data = r.entry;

    assign ext_valid = r.ext_valid;
    assign ext_data = r.ext_data;

    assign trace_full = r.full;
    assign stop_hit = r.stopped;
    assign entries_left = r.remain;

endmodule // btr_recorder

`default_nettype wire

// File: sim/btr_recorder_chk.sv
// Purpose: port checker of the branch trace recorder
// Assumes: one clock, async active-low reset
// Notes: tracks loaded setup values to judge readback

`timescale 1ns/100ps
`default_nettype none

module btr_recorder_chk #(
    parameter int CW = btr_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic core_stall,
    input wire logic mss_load,
    input wire logic [23:0] mss_base,
    input wire logic [15:0] mss_count,
    input wire logic cp_load,
    input wire logic [23:0] cp_base,
    input wire logic [15:0] cp_count,
    input wire logic mem_req,
    input wire logic [23:0] mem_addr,
    input wire logic [63:0] mem_data,
    input wire logic mem_ack,
    input wire logic ext_rd,
    input wire logic [7:0] ext_code,
    input wire logic ext_valid,
    input wire logic [23:0] ext_data,
    input wire logic trace_full,
    input wire logic stop_hit,
    input wire logic [CW-1:0] entries_left
);
    // ********
    // held setup copy
    // ********
    logic [23:0] base_h; // start address last loaded
    logic [15:0] cnt_h; // count last loaded
    // maintenance wins a clash, as in the design
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            base_h <= 24'h000000;
            cnt_h <= 16'h0000;
        end else if (mss_load) begin
            base_h <= mss_base;
            cnt_h <= mss_count;
        end else if (cp_load) begin
            base_h <= cp_base;
            cnt_h <= cp_count;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_wait; // store waiting for storage
        mem_req && !mem_ack;
    endsequence
    sequence s_done; // store answered, no new setup
        mem_req && mem_ack && !mss_load && !cp_load;
    endsequence
    property p_stall;
        core_stall == mem_req;
    endproperty
    a_stall: assert property (p_stall) else $error("stall differs from store");
    property p_hold;
        s_wait |=> mem_req && $stable(mem_addr) && $stable(mem_data);
    endproperty
    a_hold: assert property (p_hold) else $error("store dropped or changed");
    property p_release;
        s_done |=> !mem_req;
    endproperty
    a_release: assert property (p_release) else $error("store kept after ack");
    property p_step;
        s_done ##0 (entries_left > 1) |=> mem_addr == $past(mem_addr) + 24'h000008
            && entries_left == $past(entries_left) - 1;
    endproperty
    a_step: assert property (p_step) else $error("pointer or count not stepped");
    property p_level;
        mem_req |-> mem_data[63:59] == 5'h00 && mem_data[31:27] == 5'h00;
    endproperty
    a_level: assert property (p_level) else $error("level byte not binary");
    property p_full;
        trace_full |-> !mem_req;
    endproperty
    a_full: assert property (p_full) else $error("store while full");
    property p_stop;
        stop_hit |-> !mem_req;
    endproperty
    a_stop: assert property (p_stop) else $error("store after stop");
    property p_base;
        ext_rd && ext_code == btr_pkg::EXT_CODE_BASE |=> ext_valid && ext_data == $past(base_h);
    endproperty
    a_base: assert property (p_base) else $error("bad start address readback");
    property p_cnt;
        ext_rd && ext_code == btr_pkg::EXT_CODE_CNT |=> ext_valid
            && ext_data == {8'h00, $past(cnt_h)};
    endproperty
    a_cnt: assert property (p_cnt) else $error("bad count readback");
endmodule // btr_recorder_chk

`default_nettype wire

// File: sim/btr_mem_model.sv
// Purpose: storage write port seen by the recorder
// Assumes: one store outstanding at a time
// Notes: lat sets answer delay, zero is prompt

`timescale 1ns/100ps
`default_nettype none

module btr_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mem_req,
    input wire logic [23:0] mem_addr,
    input wire logic [63:0] mem_data,
    input wire logic [3:0] lat,
    output logic mem_ack,
    output logic [23:0] last_addr,
    output logic [63:0] last_data,
    output logic [7:0] n_st
);
    logic [3:0] wait_cnt; // cycles the store has waited
    // one-cycle ack pulse, entry captured with it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack <= 1'b0;
            wait_cnt <= 4'h0;
            last_addr <= 24'h000000;
            last_data <= 64'h0;
            n_st <= 8'h00;
        end else if (mem_ack) begin
            mem_ack <= 1'b0; // request drops after this edge
            wait_cnt <= 4'h0;
        end else if (mem_req) begin
            if (wait_cnt == lat) begin
                mem_ack <= 1'b1;
                last_addr <= mem_addr;
                last_data <= mem_data;
                n_st <= n_st + 8'h01;
            end else begin
                wait_cnt <= wait_cnt + 4'h1; // slow storage
            end
        end
    end
endmodule // btr_mem_model

`default_nettype wire

// File: sim/testbench.sv
// Purpose: self-checking bench of the branch trace recorder
// Assumes: storage answered by btr_mem_model
// Notes: inputs change on the falling edge

`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic clk = 1'b0; // 10 MHz
    logic rst_n, ev_valid, core_stall, trace_enable, wrap_enable, stop_enable;
    logic mss_load, cp_load, mem_req, mem_ack, ext_rd, ext_valid, trace_full, stop_hit;
    btr_pkg::btr_kind_type ev_kind;
    logic [2:0] ev_src_level, ev_tgt_level;
    logic [23:0] ev_src_addr, ev_tgt_addr, stop_addr, range_lo, range_hi;
    logic [23:0] mss_base, cp_base, mem_addr, ext_data, last_addr;
    logic [4:0] level_sel;
    logic [15:0] mss_count, cp_count, entries_left;
    logic [63:0] mem_data, last_data;
    logic [7:0] ext_code, n_st;
    logic [3:0] lat; // storage answer delay
    int n_errors = 0;
    int checks = 0;

    always #50 clk = ~clk;

    btr_recorder btr_recorder_inst (.clk(clk), .rst_n(rst_n), .ev_valid(ev_valid),
        .ev_kind(ev_kind), .ev_src_level(ev_src_level), .ev_src_addr(ev_src_addr),
        .ev_tgt_level(ev_tgt_level), .ev_tgt_addr(ev_tgt_addr), .core_stall(core_stall),
        .trace_enable(trace_enable), .wrap_enable(wrap_enable), .stop_enable(stop_enable),
        .stop_addr(stop_addr), .range_lo(range_lo), .range_hi(range_hi),
        .level_sel(level_sel), .mss_load(mss_load), .mss_base(mss_base),
        .mss_count(mss_count), .cp_load(cp_load), .cp_base(cp_base), .cp_count(cp_count),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_data(mem_data), .mem_ack(mem_ack),
        .ext_rd(ext_rd), .ext_code(ext_code), .ext_valid(ext_valid), .ext_data(ext_data),
        .trace_full(trace_full), .stop_hit(stop_hit), .entries_left(entries_left));

    btr_mem_model btr_mem_model_inst (.clk(clk), .rst_n(rst_n), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_data(mem_data), .lat(lat), .mem_ack(mem_ack),
        .last_addr(last_addr), .last_data(last_data), .n_st(n_st));

    // ********
    // tasks
    // ********
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        if (n_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // expected entry; branch kinds repeat the current level
    function automatic logic [63:0] ent(input logic [1:0] k, input logic [2:0] sl,
        input logic [23:0] sa, input logic [2:0] tl, input logic [23:0] ta);
        logic [2:0] g;
        g = (k < 2'h2) ? sl : tl;
        return {5'h00, sl, sa, 5'h00, g, ta};
    endfunction

    // other loader gets inverted values so a wrong pick shows
    task automatic load(input logic m, input logic [23:0] b, input logic [15:0] c);
        {mss_base, mss_count} = m ? {b, c} : ~{b, c};
        {cp_base, cp_count} = m ? ~{b, c} : {b, c};
        mss_load = m;
        cp_load = !m;
        @(negedge clk);
        {mss_load, cp_load} = 2'b00;
        repeat (2) @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] code, input logic [23:0] exp);
        ext_code = code;
        ext_rd = 1'b1;
        @(negedge clk);
        ext_rd = 1'b0;
        check(ext_valid, 1'b1);
        check(ext_data, exp);
        @(negedge clk);
    endtask

    // one core event; st says whether a store is expected at ea
    task automatic fire(input logic [1:0] k, input logic [2:0] sl, input logic [23:0] sa,
        input logic [2:0] tl, input logic [23:0] ta, input logic st, input logic [23:0] ea);
        logic [7:0] n0;
        n0 = n_st;
        ev_kind = btr_pkg::btr_kind_type'(k);
        {ev_src_level, ev_src_addr, ev_tgt_level, ev_tgt_addr} = {sl, sa, tl, ta};
        ev_valid = 1'b1;
        @(negedge clk);
        ev_valid = 1'b0;
        @(negedge clk);
        while (core_stall !== 1'b0) @(negedge clk);
        check(n_st, n0 + 8'(st));
        if (st) begin
            check(last_addr, ea);
            check(last_data, ent(k, sl, sa, tl, ta));
        end
    endtask

    // ********
    // tests
    // ********
    initial begin
        {rst_n, ev_valid, trace_enable, wrap_enable, stop_enable, mss_load, cp_load} = '0;
        {ev_src_level, ev_tgt_level, ev_src_addr, ev_tgt_addr, stop_addr} = '0;
        {mss_base, cp_base, mss_count, cp_count, ext_rd, ext_code, lat} = '0;
        ev_kind = btr_pkg::KIND_BRANCH;
        // idle and timer code lie outside
        range_lo = 24'h001000;
        range_hi = 24'h001fff;
        level_sel = 5'h1f;
        repeat (2) @(negedge clk);
        check(mem_req, 1'b0);
        check(entries_left, 16'h0000);
        rst_n = 1'b1;
        trace_enable = 1'b1;
        load(1'b1, 24'h008000, 16'h0004);
        check(entries_left, 16'h0004);
        rd(8'h7b, 24'h008000);
        rd(8'h7c, 24'h000004);
        rd(8'h10, 24'h000000);
        // every kind, storage ever slower
        for (int k = 0; k < 4; k++) begin
            lat = 4'(k);
            fire(2'(k), 3'(k + 1), 24'h001000 + 24'(k), 3'(k + 2), 24'h001800 + 24'(k),
                1'b1, 24'h008000 + 24'(8 * k));
            if (k < 3) check(entries_left, 16'(3 - k));
        end
        check(trace_full, 1'b1);
        fire(2'h0, 3'h1, 24'h001100, 3'h1, 24'h001104, 1'b0, 24'h0);
        wrap_enable = 1'b1;
        load(1'b1, 24'h00a000, 16'h0002);
        for (int i = 0; i < 3; i++) begin
            fire(2'h1, 3'h2, 24'h001200, 3'h2, 24'h001210, 1'b1,
                24'h00a000 + 24'(8 * (i % 2)));
        end
        fire(2'h0, 3'h2, 24'h003000, 3'h2, 24'h003100, 1'b0, 24'h0);
        level_sel = 5'h02;
        fire(2'h0, 3'h1, 24'h001100, 3'h1, 24'h001104, 1'b0, 24'h0);
        fire(2'h0, 3'h2, 24'h001100, 3'h2, 24'h001104, 1'b1, 24'h00a008);
        level_sel = 5'h1f;
        stop_enable = 1'b1;
        stop_addr = 24'h001234;
        fire(2'h3, 3'h4, 24'h001234, 3'h2, 24'h001300, 1'b1, 24'h00a000);
        check(stop_hit, 1'b1);
        fire(2'h0, 3'h2, 24'h001240, 3'h2, 24'h001250, 1'b0, 24'h0);
        trace_enable = 1'b0;
        @(negedge clk);
        check(stop_hit, 1'b0);
        trace_enable = 1'b1;
        stop_enable = 1'b0;
        load(1'b0, 24'h00c000, 16'h0005);
        rd(8'h7b, 24'h00c000);
        load(1'b1, 24'h00d000, 16'h0006);
        rd(8'h7b, 24'h00d000);
        rd(8'h7c, 24'h000006);
        check(stop_hit, 1'b0);
        check(entries_left, 16'h0006);
        fire(2'h2, 3'h5, 24'h001500, 3'h1, 24'h001600, 1'b1, 24'h00d000);
        stop_test;
    end

    // hang guard, well past the planned run
    initial begin
        repeat (2000) @(posedge clk);
        n_errors++;
        stop_test;
    end
endmodule // testbench

bind btr_recorder btr_recorder_chk #(.CW(CW)) btr_recorder_chk_inst (.clk(clk),
    .rst_n(rst_n), .core_stall(core_stall), .mss_load(mss_load), .mss_base(mss_base),
    .mss_count(mss_count), .cp_load(cp_load), .cp_base(cp_base), .cp_count(cp_count),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_data(mem_data), .mem_ack(mem_ack),
    .ext_rd(ext_rd), .ext_code(ext_code), .ext_valid(ext_valid), .ext_data(ext_data),
    .trace_full(trace_full), .stop_hit(stop_hit), .entries_left(entries_left));

`default_nettype wire
